// ===== include/vac_pkg.sv
// Constants and types for the vibration alarm configuration block.
package vac_pkg;
    localparam int NUM_RATES = 4;
    localparam int NUM_BANDS = 6;
    localparam int NUM_FIELDS = 8;
    localparam int NUM_ENTRIES = NUM_RATES * NUM_BANDS;
    localparam int FRAME_BITS = 16;
    localparam logic [6:0] ADDR_BAND_LOW = 7'h20;
    localparam logic [6:0] ADDR_BANK_LAST = 7'h2F;
    localparam logic [6:0] ADDR_Y_LEVEL2 = 7'h2C;
    localparam logic [6:0] ADDR_Z_LEVEL2 = 7'h2E;
    localparam logic [6:0] ADDR_POINTER = 7'h30;
    localparam logic [6:0] ADDR_SYS_THRESHOLD = 7'h32;
    localparam logic [6:0] ADDR_CONTROL = 7'h34;
    localparam logic [6:0] ADDR_PIN_POLARITY = 7'h36;
    localparam logic [6:0] ADDR_STATUS = 7'h3C;
    localparam logic [2:0] FLD_BAND_HIGH = 3'h1;
    localparam logic [2:0] FLD_X1 = 3'h2;
    localparam logic [2:0] FLD_Z1 = 3'h4;
    localparam logic [2:0] FLD_X2 = 3'h5;
    localparam logic [2:0] FLD_Y2 = 3'h6;
    localparam logic [2:0] FLD_Z2 = 3'h7;
    localparam logic [15:0] BIN_MASK = 16'h0FFF;
    localparam logic [15:0] CONTROL_RESET = 16'h0080;
    localparam logic [15:0] PIN_POLARITY_RESET = 16'h007B;
    localparam logic [15:0] ZERO_RESET = 16'h0000;
    localparam int PTR_RATE_HI = 9;
    localparam int PTR_RATE_LO = 8;
    localparam int PTR_BAND_HI = 2;
    localparam logic [2:0] BAND_FIRST = 3'h1;
    localparam logic [2:0] BAND_LAST = 3'h6;
    localparam int CTL_NO_READ_CLEAR = 12;
    localparam int CTL_DELAY_HI = 11;
    localparam int CTL_DELAY_LO = 8;
    localparam int CTL_LATCH = 7;
    localparam int CTL_PIN_ENABLE = 6;
    localparam int CTL_SYS_LESS = 5;
    localparam int CTL_SYS_TEMP = 4;
    localparam int CTL_SYS_ENABLE = 3;
    localparam int CTL_Z_ENABLE = 2;
    localparam int CTL_X_ENABLE = 0;
    localparam int STAT_LSB = 8;
    localparam int FLAG_SYS = 6;
    localparam logic [6:0] SPECTRAL_FLAGS = 7'h3F;
    localparam logic [6:0] Z_FLAGS = 7'h24;
    localparam logic [6:0] SYS_FLAG = 7'h40;
    localparam logic [3:0] DELAY_MIN = 4'h1;
    localparam logic [3:0] COUNT_MAX = 4'hF;
    localparam logic [4:0] LAST_BIT = 5'h0F;

    typedef enum logic [1:0] {
        MODE_OTHER = 2'b00,
        MODE_MANUAL_SPECTRUM = 2'b01,
        MODE_AUTO_SPECTRUM = 2'b10,
        MODE_TIME_CAPTURE = 2'b11
    } vac_mode_type;

    typedef struct packed {
        logic valid;
        logic [11:0] bin;
        logic [15:0] mag_z;
        logic [15:0] mag_y;
        logic [15:0] mag_x;
    } vac_spec_type;

    typedef struct packed {
        logic valid;
        logic [15:0] z_stat;
        logic [15:0] root_sum_square_combine;
    } vac_tcap_type;
endpackage : vac_pkg

// ===== verilog/vac_alarm_config.sv
// Alarm configuration registers, banked band settings and alarm evaluation.
//
// Notes on behaviour
// - Spectral modes: y level-2 threshold of any band at the selected rate raises alarm 2.
// - Spectral modes: z level-2 threshold of any band at the selected rate raises alarm 2.
// - Time capture compares z level-2 with z statistic, or combined value.
// - Thresholds are 16-bit words in the matching axis buffer format.
// - Pointer bits 9:8 pick rate, bits 2:0 pick band 1..6.
// - Six alarms are kept for each of four rate settings.
// - Writing the pointer makes the band registers show that alarm.
// - Band and threshold writes update the alarm the pointer selects.
// - System threshold compares temperature when bit set, supply when clear.
// - Status read clears spectral flags unless control bit 12 is set.
// - Control bits 11:8 give records required before a spectral flag.
// - Control bit 7 latches flags until the clear-status command or, for spectral flags, a status read.
// - Control bit 6 puts alarm 1 and alarm 2 on the pins.
// - Control bit 5 picks less-than, else greater-than system trigger.
// - Control bits 3..0 enable system, z, y and x alarms.
// - Pin polarity bits 1 and 0 choose active high or low.
// - Reset: control 0x0080, polarity 0x007B, other registers zero.
// - Band limits are bin numbers in bits 11:0; upper bits ignored.
// - Status bit 14 is system, bits 8..10 level 1, 11..13 level 2.
`timescale 1ns/1ns
module vac_alarm_config (
    input wire logic mclk_in,
    input wire logic reset_in,
    input wire logic spi_cs_n_in,
    input wire logic spi_sclk_in,
    input wire logic spi_mosi_in,
    output logic spi_miso_out,
    output logic spi_miso_oe_out,
    input wire vac_pkg::vac_mode_type mode_in,
    input wire logic root_sum_square_combine_in,
    input wire logic [1:0] rate_select_in,
    input wire vac_pkg::vac_spec_type spec_in,
    input wire logic record_end_in,
    input wire vac_pkg::vac_tcap_type tcap_in,
    input wire logic [15:0] temperature_in,
    input wire logic [15:0] supply_in,
    input wire logic system_sample_in,
    input wire logic clear_status_in,
    output logic first_alarm_output_pin_out,
    output logic second_alarm_output_pin_out
);
    localparam int NE = vac_pkg::NUM_ENTRIES;
    localparam int NB = vac_pkg::NUM_BANDS;
    localparam int NF = vac_pkg::NUM_FIELDS;

    function automatic logic [4:0] entry_of(logic [1:0] r, logic [2:0] b);
        return 5'(int'(r) * NB + int'(b) - 1);
    endfunction : entry_of

    function automatic logic [15:0] merge(logic [15:0] w, logic hi,
                                          logic [7:0] v);
        return hi ? {v, w[7:0]} : {w[15:8], v};
    endfunction : merge

    // Serial port: pins pass two flip-flops before any logic reads them.
    logic [2:0] sclk_sq;
    logic [2:0] cs_sq;
    logic [1:0] mosi_sq;
    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            sclk_sq <= 3'h7;
            cs_sq <= 3'h7;
            mosi_sq <= 2'h0;
        end else begin
            sclk_sq <= {sclk_sq[1:0], spi_sclk_in};
            cs_sq <= {cs_sq[1:0], spi_cs_n_in};
            mosi_sq <= {mosi_sq[0], spi_mosi_in};
        end
    end

    logic sclk_rise;
    logic sclk_fall;
    logic cs_fall;
    logic cs_active;
    assign sclk_rise = sclk_sq[1] & ~sclk_sq[2];
    assign sclk_fall = ~sclk_sq[1] & sclk_sq[2];
    assign cs_fall = ~cs_sq[1] & cs_sq[2];
    assign cs_active = ~cs_sq[1];

    logic [15:0] rx_q, rx_d, tx_q, tx_d, cmd, rdata;
    logic [4:0] cnt_q, cnt_d;
    logic [6:0] rd_addr_q, rd_addr_d;
    logic wr_stb;
    logic stat_read;
    logic [15:0] ptr_q, ptr_d, smag_q, smag_d, ctrl_q, ctrl_d, dio_q, dio_d;
    logic [15:0] bank_q [NE][NF];
    logic [15:0] bank_d [NE][NF];
    logic [6:0] stat_q, stat_d;
    logic [3:0] run_q [NB][6];
    logic [3:0] run_d [NB][6];
    logic [5:0] hit_q [NB];
    logic [5:0] hit_d [NB];
    logic [1:0] pin_q, pin_d;
    logic ptr_ok;
    logic [4:0] ptr_entry;

    assign cmd = {rx_q[14:0], mosi_sq[1]};
    assign ptr_ok = ptr_q[vac_pkg::PTR_BAND_HI:0] >= vac_pkg::BAND_FIRST &&
                    ptr_q[vac_pkg::PTR_BAND_HI:0] <= vac_pkg::BAND_LAST;
    assign ptr_entry = entry_of(
        ptr_q[vac_pkg::PTR_RATE_HI:vac_pkg::PTR_RATE_LO],
        ptr_q[vac_pkg::PTR_BAND_HI:0]);

    // Reads of banked words show the entry the pointer selects.
    always_comb begin
        rdata = vac_pkg::ZERO_RESET;
        if (rd_addr_q >= vac_pkg::ADDR_BAND_LOW &&
            rd_addr_q <= vac_pkg::ADDR_BANK_LAST) begin
            if (ptr_ok) begin
                rdata = bank_q[ptr_entry][rd_addr_q[3:1]];
            end
        end else begin
            unique case (rd_addr_q)
                vac_pkg::ADDR_POINTER: rdata = ptr_q;
                vac_pkg::ADDR_SYS_THRESHOLD: rdata = smag_q;
                vac_pkg::ADDR_CONTROL: rdata = ctrl_q;
                vac_pkg::ADDR_PIN_POLARITY: rdata = dio_q;
                vac_pkg::ADDR_STATUS: rdata = 16'(stat_q) << vac_pkg::STAT_LSB;
                default: rdata = vac_pkg::ZERO_RESET;
            endcase
        end
    end

    // Frame of sixteen bits: write commands carry one byte, reads answer
    // in the following frame.
    always_comb begin
        rx_d = rx_q;
        tx_d = tx_q;
        cnt_d = cnt_q;
        rd_addr_d = rd_addr_q;
        wr_stb = 1'b0;
        stat_read = 1'b0;
        if (cs_fall) begin
            cnt_d = 5'h00;
            tx_d = rdata;
            stat_read = rd_addr_q == vac_pkg::ADDR_STATUS;
        end else if (cs_active && sclk_rise) begin
            rx_d = cmd;
            cnt_d = cnt_q + 5'h01;
            if (cnt_q == vac_pkg::LAST_BIT) begin
                wr_stb = cmd[15];
                if (!cmd[15]) begin
                    rd_addr_d = {cmd[14:9], 1'b0};
                end
            end
        end else if (cs_active && sclk_fall && cnt_q != 5'h00) begin
            tx_d = {tx_q[14:0], 1'b0};
        end
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            rx_q <= vac_pkg::ZERO_RESET;
            tx_q <= vac_pkg::ZERO_RESET;
            cnt_q <= 5'h00;
            rd_addr_q <= 7'h00;
        end else begin
            rx_q <= rx_d;
            tx_q <= tx_d;
            cnt_q <= cnt_d;
            rd_addr_q <= rd_addr_d;
        end
    end

    assign spi_miso_out = tx_q[15];
    assign spi_miso_oe_out = cs_active;

    // Register writes; banked words land in the pointed entry.
    always_comb begin
        ptr_d = ptr_q;
        smag_d = smag_q;
        ctrl_d = ctrl_q;
        dio_d = dio_q;
        bank_d = bank_q;
        if (wr_stb) begin
            if (cmd[14:8] >= vac_pkg::ADDR_BAND_LOW &&
                cmd[14:8] <= vac_pkg::ADDR_BANK_LAST) begin
                if (ptr_ok) begin
                    bank_d[ptr_entry][cmd[11:9]] = merge(
                        bank_q[ptr_entry][cmd[11:9]], cmd[8], cmd[7:0]);
                    if (cmd[11:9] <= vac_pkg::FLD_BAND_HIGH) begin
                        bank_d[ptr_entry][cmd[11:9]] &= vac_pkg::BIN_MASK;
                    end
                end
            end else begin
                unique case ({cmd[14:9], 1'b0})
                    vac_pkg::ADDR_POINTER:
                        ptr_d = merge(ptr_q, cmd[8], cmd[7:0]);
                    vac_pkg::ADDR_SYS_THRESHOLD:
                        smag_d = merge(smag_q, cmd[8], cmd[7:0]);
                    vac_pkg::ADDR_CONTROL:
                        ctrl_d = merge(ctrl_q, cmd[8], cmd[7:0]);
                    vac_pkg::ADDR_PIN_POLARITY:
                        dio_d = merge(dio_q, cmd[8], cmd[7:0]);
                    default: ;
                endcase
            end
        end
    end

    // Evaluation; flag order is {z2, y2, x2, z1, y1, x1} below system.
    logic [6:0] ev;
    logic [6:0] upd;
    logic [6:0] clr;
    logic [3:0] need;
    logic [15:0] sys_val;
    logic [15:0] tc_val;
    logic spectral;
    always_comb begin
        logic [15:0] e [NF];
        logic [5:0] hit;
        e = bank_q[0];
        hit = 6'h00;
        ev = 7'h00;
        upd = 7'h00;
        hit_d = hit_q;
        run_d = run_q;
        spectral = mode_in == vac_pkg::MODE_MANUAL_SPECTRUM ||
                   mode_in == vac_pkg::MODE_AUTO_SPECTRUM;
        need = ctrl_q[vac_pkg::CTL_DELAY_HI:vac_pkg::CTL_DELAY_LO];
        if (need < vac_pkg::DELAY_MIN) begin
            need = vac_pkg::DELAY_MIN;
        end
        for (int b = 0; b < NB; b++) begin
            e = bank_q[entry_of(rate_select_in, 3'(b + 1))];
            for (int k = 0; k < 6; k++) begin
                hit[k] = spec_in.valid && spectral &&
                    ctrl_q[vac_pkg::CTL_X_ENABLE + k % 3] &&
                    spec_in.bin >= e[0][11:0] && spec_in.bin <= e[1][11:0] &&
                    spec_in[16 * (k % 3) +: 16] >
                    e[int'(vac_pkg::FLD_X1) + k];
            end
            hit_d[b] = hit_q[b] | hit;
            if (record_end_in && spectral) begin
                hit_d[b] = 6'h00;
                for (int k = 0; k < 6; k++) begin
                    run_d[b][k] = !hit_q[b][k] ? 4'h0 :
                        (run_q[b][k] == vac_pkg::COUNT_MAX ?
                         vac_pkg::COUNT_MAX : run_q[b][k] + 4'h1);
                    ev[k] = ev[k] | (run_d[b][k] >= need);
                end
            end
        end
        if (record_end_in && spectral) begin
            upd = vac_pkg::SPECTRAL_FLAGS;
        end
        e = bank_q[ptr_entry];
        tc_val = root_sum_square_combine_in ? tcap_in.root_sum_square_combine : tcap_in.z_stat;
        if (tcap_in.valid && mode_in == vac_pkg::MODE_TIME_CAPTURE &&
            ctrl_q[vac_pkg::CTL_Z_ENABLE] && ptr_ok) begin
            upd = upd | vac_pkg::Z_FLAGS;
            ev[2] = tc_val > e[vac_pkg::FLD_Z1];
            ev[5] = tc_val > e[vac_pkg::FLD_Z2];
        end
        sys_val = ctrl_q[vac_pkg::CTL_SYS_TEMP] ? temperature_in : supply_in;
        if (system_sample_in && ctrl_q[vac_pkg::CTL_SYS_ENABLE]) begin
            upd = upd | vac_pkg::SYS_FLAG;
            ev[vac_pkg::FLAG_SYS] = ctrl_q[vac_pkg::CTL_SYS_LESS] ?
                sys_val < smag_q : sys_val > smag_q;
        end
        clr = {7{clear_status_in}};
        if (stat_read && !ctrl_q[vac_pkg::CTL_NO_READ_CLEAR]) begin
            clr = clr | vac_pkg::SPECTRAL_FLAGS;
        end
        stat_d = ctrl_q[vac_pkg::CTL_LATCH] ? stat_q : stat_q & ~upd;
        stat_d = (stat_d & ~clr) | ev;
        pin_d[0] = ~((ctrl_q[vac_pkg::CTL_PIN_ENABLE] & |stat_q[2:0]) ^
                     dio_q[0]);
        pin_d[1] = ~((ctrl_q[vac_pkg::CTL_PIN_ENABLE] & |stat_q[5:3]) ^
                     dio_q[1]);
    end

    always_ff @(posedge mclk_in or posedge reset_in) begin
        if (reset_in) begin
            ptr_q <= vac_pkg::ZERO_RESET;
            smag_q <= vac_pkg::ZERO_RESET;
            ctrl_q <= vac_pkg::CONTROL_RESET;
            dio_q <= vac_pkg::PIN_POLARITY_RESET;
            stat_q <= 7'h00;
            pin_q <= ~vac_pkg::PIN_POLARITY_RESET[1:0];
            for (int i = 0; i < NE; i++) begin
                for (int f = 0; f < NF; f++) begin
                    bank_q[i][f] <= vac_pkg::ZERO_RESET;
                end
            end
            for (int b = 0; b < NB; b++) begin
                hit_q[b] <= 6'h00;
                for (int k = 0; k < 6; k++) begin
                    run_q[b][k] <= 4'h0;
                end
            end
        end else begin
            ptr_q <= ptr_d;
            smag_q <= smag_d;
            ctrl_q <= ctrl_d;
            dio_q <= dio_d;
            stat_q <= stat_d;
            pin_q <= pin_d;
            bank_q <= bank_d;
            hit_q <= hit_d;
            run_q <= run_d;
        end
    end

    assign first_alarm_output_pin_out = pin_q[0];
    assign second_alarm_output_pin_out = pin_q[1];

    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (reset_in);

    property p_pin_idle;
        !ctrl_q[vac_pkg::CTL_PIN_ENABLE] |=> pin_q == ~$past(dio_q[1:0]);
    endproperty
    a_pin_idle: assert property (p_pin_idle)
        else $error("Alarm pins not at inactive level.");

    property p_pin_alarm;
        ctrl_q[vac_pkg::CTL_PIN_ENABLE] && |stat_q[2:0] |=>
            first_alarm_output_pin_out == $past(dio_q[0]);
    endproperty
    a_pin_alarm: assert property (p_pin_alarm)
        else $error("First alarm pin not active.");

    property p_sys_less;
        system_sample_in && ctrl_q[vac_pkg::CTL_SYS_ENABLE] &&
        ctrl_q[vac_pkg::CTL_SYS_LESS] && sys_val < smag_q |=>
            stat_q[vac_pkg::FLAG_SYS];
    endproperty
    a_sys_less: assert property (p_sys_less)
        else $error("System alarm missed below threshold.");

    property p_sys_enable;
        $rose(stat_q[vac_pkg::FLAG_SYS]) |->
            $past(ctrl_q[vac_pkg::CTL_SYS_ENABLE] && system_sample_in);
    endproperty
    a_sys_enable: assert property (p_sys_enable)
        else $error("System flag rose while disabled.");

    property p_latch_hold;
        ctrl_q[vac_pkg::CTL_LATCH] && stat_q[vac_pkg::FLAG_SYS] &&
        !clear_status_in |=> stat_q[vac_pkg::FLAG_SYS] [*1];
    endproperty
    a_latch_hold: assert property (p_latch_hold)
        else $error("Latched system flag dropped without clear.");

    property p_read_clear;
        stat_read && !ctrl_q[vac_pkg::CTL_NO_READ_CLEAR] &&
        !record_end_in && !tcap_in.valid |=> stat_q[5:0] == 6'h00;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("Spectral flags survived a status read.");

    property p_spec_cause;
        $rose(stat_q[4]) |-> $past(record_end_in) || $past(tcap_in.valid);
    endproperty
    a_spec_cause: assert property (p_spec_cause)
        else $error("Level-2 y flag rose without a record.");

    property p_bank_write;
        wr_stb && ptr_ok && !cmd[8] && cmd[14:8] == vac_pkg::ADDR_Z_LEVEL2 |=>
            bank_q[$past(ptr_entry)][vac_pkg::FLD_Z2][7:0] == $past(cmd[7:0]);
    endproperty
    a_bank_write: assert property (p_bank_write)
        else $error("Banked z threshold write lost.");
endmodule : vac_alarm_config

// ===== dv/vac_spi_host.sv
// SPI host model that sends command frames to the alarm block.
`timescale 1ns/1ns
module vac_spi_host (
    input wire logic mclk_in,
    input wire logic miso_in,
    input wire logic miso_oe_in,
    output logic cs_n_out,
    output logic sclk_out,
    output logic mosi_out
);
    initial begin
        cs_n_out = 1'b1;
        sclk_out = 1'b1;
        mosi_out = 1'b0;
    end

    // Sends one word in mode 3 and returns the word shifted back.
    // A released data line reads as ones so stale bits never match.
    task automatic xfer(input logic [15:0] cmd, output logic [15:0] rsp);
        @(posedge mclk_in);
        cs_n_out <= 1'b0;
        repeat (6) @(posedge mclk_in);
        for (int i = 15; i >= 0; i--) begin
            sclk_out <= 1'b0;
            mosi_out <= cmd[i];
            repeat (5) @(posedge mclk_in);
            sclk_out <= 1'b1;
            rsp[i] = miso_oe_in ? miso_in : 1'b1;
            repeat (5) @(posedge mclk_in);
        end
        repeat (4) @(posedge mclk_in);
        cs_n_out <= 1'b1;
        mosi_out <= ~mosi_out;
        repeat (6) @(posedge mclk_in);
    endtask : xfer
endmodule : vac_spi_host

// ===== dv/vac_alarm_config_bench.sv
// Self-checking bench for the vibration alarm configuration block.
`timescale 1ns/1ns
module vac_alarm_config_bench;
    logic mclk_in = 1'b0;
    logic reset_in = 1'b1;
    logic cs_n, sclk, mosi, miso, miso_oe, pin1, pin2;
    vac_pkg::vac_mode_type mode = vac_pkg::MODE_OTHER;
    logic rss_on = 1'b0;
    logic [1:0] rate = 2'h0;
    vac_pkg::vac_spec_type spec = '0;
    logic rec_end = 1'b0;
    vac_pkg::vac_tcap_type tcap = '0;
    logic [15:0] temp = 16'h0000;
    logic [15:0] supply = 16'h0000;
    logic sys_smp = 1'b0;
    logic clr = 1'b0;
    int mismatches = 0;
    int cmp_count = 0;

    always #5 mclk_in = ~mclk_in;

    vac_spi_host i_host (.mclk_in(mclk_in), .miso_in(miso),
        .miso_oe_in(miso_oe), .cs_n_out(cs_n), .sclk_out(sclk),
        .mosi_out(mosi));

    vac_alarm_config i_dut (.mclk_in(mclk_in), .reset_in(reset_in),
        .spi_cs_n_in(cs_n), .spi_sclk_in(sclk), .spi_mosi_in(mosi),
        .spi_miso_out(miso), .spi_miso_oe_out(miso_oe), .mode_in(mode),
        .root_sum_square_combine_in(rss_on), .rate_select_in(rate),
        .spec_in(spec), .record_end_in(rec_end), .tcap_in(tcap),
        .temperature_in(temp), .supply_in(supply),
        .system_sample_in(sys_smp), .clear_status_in(clr),
        .first_alarm_output_pin_out(pin1),
        .second_alarm_output_pin_out(pin2));

    task automatic close_out;
        if (mismatches == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : close_out

    task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word

    task automatic chk_bit(input logic got, input logic exp);
        cmp_count++;
        if (got !== exp) begin
            mismatches++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bit

    // Writes a word as two byte frames, high byte first.
    task automatic wr(input logic [6:0] addr, input logic [15:0] data);
        logic [15:0] rsp;
        i_host.xfer({1'b1, addr | 7'h01, data[15:8]}, rsp);
        i_host.xfer({1'b1, addr, data[7:0]}, rsp);
    endtask : wr

    // The answer to a read arrives in the following frame.
    task automatic rd(input logic [6:0] addr, output logic [15:0] data);
        logic [15:0] rsp;
        i_host.xfer({1'b0, addr, 8'h00}, rsp);
        i_host.xfer(16'h0000, data);
    endtask : rd

    // Bit 0 clears status, bit 1 samples the system value, bit 2 captures.
    task automatic strobe(input logic [2:0] s);
        @(posedge mclk_in);
        clr <= s[0];
        sys_smp <= s[1];
        tcap.valid <= s[2];
        @(posedge mclk_in);
        clr <= 1'b0;
        sys_smp <= 1'b0;
        tcap.valid <= 1'b0;
        repeat (3) @(posedge mclk_in);
    endtask : strobe

    // One record: a bin under test, then bin 21 just past the band.
    task automatic rec(input logic [11:0] bin, input logic [15:0] my,
                       input logic [15:0] mz);
        @(posedge mclk_in);
        spec <= '{1'b1, bin, mz, my, 16'hFFFF};
        @(posedge mclk_in);
        spec <= '{1'b1, 12'h015, 16'hFFFF, 16'hFFFF, 16'hFFFF};
        @(posedge mclk_in);
        spec.valid <= 1'b0;
        rec_end <= 1'b1;
        @(posedge mclk_in);
        rec_end <= 1'b0;
        repeat (3) @(posedge mclk_in);
    endtask : rec

    task automatic t_reset;
        logic [15:0] v;
        logic [6:0] a [6];
        logic [15:0] e [6];
        a = '{vac_pkg::ADDR_CONTROL, vac_pkg::ADDR_PIN_POLARITY,
              vac_pkg::ADDR_POINTER, vac_pkg::ADDR_SYS_THRESHOLD,
              vac_pkg::ADDR_Y_LEVEL2, 7'h3E};
        e = '{16'h0080, 16'h007B, 16'h0000, 16'h0000, 16'h0000, 16'h0000};
        chk_bit(pin1, 1'b0);
        chk_bit(pin2, 1'b0);
        for (int i = 0; i < 6; i++) begin
            rd(a[i], v);
            chk_word(v, e[i]);
        end
    endtask : t_reset

    task automatic t_bank;
        logic [15:0] v;
        wr(vac_pkg::ADDR_POINTER, 16'h0203);
        wr(vac_pkg::ADDR_Y_LEVEL2, 16'h1234);
        wr(vac_pkg::ADDR_Z_LEVEL2, 16'h5678);
        wr(vac_pkg::ADDR_BAND_LOW, 16'hF123);
        wr(vac_pkg::ADDR_POINTER, 16'hFD01);
        wr(vac_pkg::ADDR_Y_LEVEL2, 16'hAAAA);
        rd(vac_pkg::ADDR_Z_LEVEL2, v);
        chk_word(v, 16'h0000);
        wr(vac_pkg::ADDR_POINTER, 16'h0007);
        wr(vac_pkg::ADDR_Y_LEVEL2, 16'h1111);
        rd(vac_pkg::ADDR_Y_LEVEL2, v);
        chk_word(v, 16'h0000);
        wr(vac_pkg::ADDR_POINTER, 16'h0101);
        rd(vac_pkg::ADDR_Y_LEVEL2, v);
        chk_word(v, 16'hAAAA);
        wr(vac_pkg::ADDR_POINTER, 16'h0203);
        rd(vac_pkg::ADDR_Y_LEVEL2, v);
        chk_word(v, 16'h1234);
        rd(vac_pkg::ADDR_Z_LEVEL2, v);
        chk_word(v, 16'h5678);
        rd(vac_pkg::ADDR_BAND_LOW, v);
        chk_word(v, 16'h0123);
    endtask : t_bank

    task automatic t_spectral;
        logic [15:0] v;
        wr(vac_pkg::ADDR_POINTER, 16'h0001);
        wr(vac_pkg::ADDR_BAND_LOW, 16'h000A);
        wr(7'h22, 16'h0014);
        wr(7'h26, 16'h0080);
        wr(7'h28, 16'h0080);
        wr(vac_pkg::ADDR_Y_LEVEL2, 16'h0100);
        wr(vac_pkg::ADDR_Z_LEVEL2, 16'h0100);
        wr(vac_pkg::ADDR_CONTROL, 16'h02C6);
        @(posedge mclk_in);
        mode <= vac_pkg::MODE_MANUAL_SPECTRUM;
        rec(12'h00F, 16'h0101, 16'h0100);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h0000);
        rec(12'h00F, 16'h0101, 16'h0100);
        chk_bit(pin1, 1'b1);
        chk_bit(pin2, 1'b1);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h1600);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h0000);
        chk_bit(pin1, 1'b0);
    endtask : t_spectral

    task automatic t_latch;
        logic [15:0] v;
        wr(vac_pkg::ADDR_PIN_POLARITY, 16'h0000);
        chk_bit(pin1, 1'b1);
        chk_bit(pin2, 1'b1);
        wr(vac_pkg::ADDR_CONTROL, 16'h12C6);
        @(posedge mclk_in);
        mode <= vac_pkg::MODE_AUTO_SPECTRUM;
        rec(12'h00A, 16'h0000, 16'h0101);
        rec(12'h00A, 16'h0000, 16'h0101);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h2400);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h2400);
        chk_bit(pin1, 1'b0);
        chk_bit(pin2, 1'b0);
        strobe(3'h1);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h0000);
        @(posedge mclk_in);
        mode <= vac_pkg::MODE_OTHER;
        rec(12'h00A, 16'hFFFF, 16'hFFFF);
        rec(12'h00A, 16'hFFFF, 16'hFFFF);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h0000);
        // Rate setting 2 has no band that covers bin 10.
        @(posedge mclk_in);
        mode <= vac_pkg::MODE_AUTO_SPECTRUM;
        rate <= 2'h2;
        rec(12'h00A, 16'hFFFF, 16'hFFFF);
        rec(12'h00A, 16'hFFFF, 16'hFFFF);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h0000);
    endtask : t_latch

    task automatic t_system;
        logic [15:0] v;
        wr(vac_pkg::ADDR_SYS_THRESHOLD, 16'h1000);
        wr(vac_pkg::ADDR_CONTROL, 16'h0098);
        @(posedge mclk_in);
        temp <= 16'h1001;
        supply <= 16'h0000;
        strobe(3'h2);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h4000);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h4000);
        strobe(3'h1);
        wr(vac_pkg::ADDR_CONTROL, 16'h00A8);
        @(posedge mclk_in);
        temp <= 16'h2000;
        supply <= 16'h0FFF;
        strobe(3'h2);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h4000);
        strobe(3'h1);
        wr(vac_pkg::ADDR_CONTROL, 16'h00A0);
        strobe(3'h2);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h0000);
        // Without latching, a later evaluation overwrites the flag.
        wr(vac_pkg::ADDR_CONTROL, 16'h0018);
        strobe(3'h2);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h4000);
        @(posedge mclk_in);
        temp <= 16'h0000;
        strobe(3'h2);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h0000);
    endtask : t_system

    task automatic t_tcap;
        logic [15:0] v;
        wr(vac_pkg::ADDR_CONTROL, 16'h0084);
        @(posedge mclk_in);
        mode <= vac_pkg::MODE_TIME_CAPTURE;
        tcap.z_stat <= 16'h0200;
        tcap.root_sum_square_combine <= 16'h0010;
        strobe(3'h4);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h2400);
        chk_bit(pin1, 1'b1);
        strobe(3'h1);
        @(posedge mclk_in);
        rss_on <= 1'b1;
        strobe(3'h4);
        rd(vac_pkg::ADDR_STATUS, v);
        chk_word(v, 16'h0000);
    endtask : t_tcap

    initial begin
        repeat (12) @(posedge mclk_in);
        reset_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        t_reset;
        t_bank;
        t_spectral;
        t_latch;
        t_system;
        t_tcap;
        close_out;
    end

    initial begin
        repeat (90000) @(posedge mclk_in);
        mismatches++;
        close_out;
    end
endmodule : vac_alarm_config_bench
